/* banked_core_register_file.sv */
// banked register file of a 32-bit core: 37 physical registers, status words,
// instruction state, exception entry and return, data lane steering by endianness
// assumes decode drives one-cycle requests on core_clk; software keeps mode bits legal
//
// Operation
// - wide 32-bit and compact 16-bit instruction states
// - compact fetch picks halfword by pc bit 1
// - state switch keeps mode and registers, loads pc
// - branch exchange bit 0 selects the state
// - exception return restores compact state
// - exception enters wide state, link, vector
// - memory is byte array, four per word
// - big endian puts byte 0 high
// - little endian puts byte 0 low
// - byte, halfword, word with natural alignment
// - seven operating modes, abort and undefined entry
// - mode changes by software or exception
// - 31 general plus six status registers
// - privileged modes other than system bank over user registers
// - link register takes pc on link
// - pc low bits read zero by state
// - current status word visible everywhere
// - fast interrupt banks registers 8 to 14
// - four modes bank stack and link
// - compact state sees eight plus sp, lr, pc
// - low registers and status words shared
// - compact sp, lr, pc map to 13-15
// - five-bit mode field encodings
// - state bit drives state indicator signal
// - interrupt disable bits mask requests
`timescale 1ns/10ps
`default_nettype none
module banked_core_register_file
    import regfile_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] rd_a_idx,
    input wire logic [3:0] rd_b_idx,
    input wire regfile_pkg::reg_wr_t wr_req,
    input wire logic advance,
    input wire logic branch_exchange,
    input wire logic [31:0] exch_operand,
    input wire logic branch_with_link,
    input wire logic [31:0] branch_target,
    input wire logic status_write,
    input wire logic status_saved_sel,
    input wire logic [31:0] status_wdata,
    input wire logic flags_write,
    input wire logic [3:0] flags_in,
    input wire logic exc_take,
    input wire regfile_pkg::exc_t exc_kind,
    input wire logic exc_return,
    input wire logic [31:0] return_addr,
    input wire logic [31:0] fetch_word,
    input wire logic big_endian,
    input wire regfile_pkg::lane_req_t lane_req,
    input wire logic irq_req,
    input wire logic fiq_req,
    output logic [31:0] rd_a_data,
    output logic [31:0] rd_b_data,
    output logic [31:0] current_status_word,
    output logic [31:0] saved_status_word,
    output logic [31:0] program_counter_reg,
    output logic [15:0] fetch_half,
    output logic [31:0] lane_data,
    output logic [3:0] lane_strobe,
    output logic align_fault,
    output logic state_indicator_signal,
    output logic privileged,
    output logic irq_take,
    output logic fiq_take
);
    import regfile_pkg::*;

    logic [31:0] gpr [0:NUM_GPR-1]; // 30 banked general slots plus the pc slot
    logic [31:0] psr_cur; // current status word
    logic [31:0] psr_saved [0:NUM_PSR-2]; // five saved words, one per exception mode
    logic [4:0] mode; // mode field view
    istate_t ist; // instruction state view
    logic [31:0] pc_aligned; // pc with low bits forced by state
    logic [31:0] next_pc; // pc after a sequential step
    logic [4:0] exc_mode; // mode entered by the exception
    logic [31:0] exc_vec; // vector of the exception
    logic [2:0] exc_sav; // saved word slot of the exception
    logic [2:0] cur_sav; // saved word slot of the current mode
    logic cur_has_sav; // current mode owns a saved word
    logic [4:0] wr_slot; // physical slot of the write port
    logic [4:0] lr_slot_exc; // link slot of the exception mode

    assign mode = psr_cur[MODE_LSB +: 5];
    assign ist = istate_t'(psr_cur[BIT_STATE]);

    // map an architectural index to a physical slot for a given mode
    // slots: 0-14 user r0-r14, 15-21 fiq r8-r14, 22/23 svc, 24/25 abt,
    // 26/27 irq, 28/29 und, 30 pc; system shares the user bank
    function automatic logic [4:0] slot_of(input logic [4:0] m, input logic [3:0] idx);
        logic [4:0] s;
        s = {1'b0, idx};
        if (idx == REG_PC) begin
            s = SLOT_PC;
        end else if (m == MODE_FIQ && idx >= 4'h8) begin
            s = SLOT_FIQ8 + {1'b0, idx} - 5'h08;
        end else if (idx >= REG_SP) begin
            case (m)
                MODE_SVC: s = SLOT_SVC_SP + {4'h0, idx[0] ^ 1'b1};
                MODE_ABT: s = SLOT_ABT_SP + {4'h0, idx[0] ^ 1'b1};
                MODE_IRQ: s = SLOT_IRQ_SP + {4'h0, idx[0] ^ 1'b1};
                MODE_UND: s = SLOT_UND_SP + {4'h0, idx[0] ^ 1'b1};
                default: s = SLOT_USR_SP + {4'h0, idx[0] ^ 1'b1};
            endcase
        end
        return s;
    endfunction

    // saved word slot of a mode; system and user have none
    function automatic logic [2:0] sav_of(input logic [4:0] m);
        case (m)
            MODE_FIQ: return 3'h0;
            MODE_IRQ: return 3'h1;
            MODE_SVC: return 3'h2;
            MODE_ABT: return 3'h3;
            MODE_UND: return 3'h4;
            default: return 3'h7;
        endcase
    endfunction

    assign cur_sav = sav_of(mode);
    assign cur_has_sav = (cur_sav != 3'h7);
    assign wr_slot = slot_of(mode, wr_req.idx);

    // pc alignment follows the state
    always_comb begin
        if (ist == ST_COMPACT) begin
            pc_aligned = {gpr[SLOT_PC][31:1], 1'b0};
            next_pc = pc_aligned + 32'h00000002;
        end else begin
            pc_aligned = {gpr[SLOT_PC][31:2], 2'b00};
            next_pc = pc_aligned + 32'h00000004;
        end
    end

    // exception decode; abort and undefined get their own modes
    always_comb begin
        case (exc_kind)
            EXC_RESET: begin
                exc_mode = MODE_SVC;
                exc_vec = VEC_RESET;
            end
            EXC_UND: begin
                exc_mode = MODE_UND;
                exc_vec = VEC_UND;
            end
            EXC_SWI: begin
                exc_mode = MODE_SVC;
                exc_vec = VEC_SWI;
            end
            EXC_PABT: begin
                exc_mode = MODE_ABT;
                exc_vec = VEC_PABT;
            end
            EXC_DABT: begin
                exc_mode = MODE_ABT;
                exc_vec = VEC_DABT;
            end
            EXC_IRQ: begin
                exc_mode = MODE_IRQ;
                exc_vec = VEC_IRQ;
            end
            EXC_FIQ: begin
                exc_mode = MODE_FIQ;
                exc_vec = VEC_FIQ;
            end
            default: begin
                exc_mode = MODE_UND;
                exc_vec = VEC_UND;
            end
        endcase
        exc_sav = sav_of(exc_mode);
        lr_slot_exc = slot_of(exc_mode, REG_LR);
    end

    // general registers: exception link beats branch link beats the write port;
    // a state switch alone touches only the pc slot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_GPR; i++) begin
                gpr[i] <= 32'h00000000;
            end
        end else if (exc_take) begin
            gpr[lr_slot_exc] <= pc_aligned;
            gpr[SLOT_PC] <= exc_vec;
        end else if (exc_return) begin
            gpr[SLOT_PC] <= return_addr;
        end else if (branch_exchange) begin
            gpr[SLOT_PC] <= {exch_operand[31:1], 1'b0};
        end else begin
            if (branch_with_link) begin
                gpr[slot_of(mode, REG_LR)] <= next_pc;
                gpr[SLOT_PC] <= branch_target;
            end else if (advance) begin
                gpr[SLOT_PC] <= next_pc;
            end
            if (wr_req.en && !branch_with_link && !(advance && wr_req.idx == REG_PC)) begin
                gpr[wr_slot] <= wr_req.data;
            end else if (wr_req.en && wr_req.idx == REG_PC && !branch_with_link) begin
                gpr[SLOT_PC] <= wr_req.data;
            end
        end
    end

    // current status word: exception entry, return, software writes, flag updates
    always_ff @(posedge core_clk) begin
        if (rst) begin
            psr_cur <= PSR_RESET;
        end else if (exc_take) begin
            psr_cur[MODE_LSB +: 5] <= exc_mode;
            psr_cur[BIT_STATE] <= ST_WIDE;
            psr_cur[BIT_IRQ_DIS] <= 1'b1;
            if (exc_mode == MODE_FIQ || exc_kind == EXC_RESET) begin
                psr_cur[BIT_FIQ_DIS] <= 1'b1;
            end
        end else if (exc_return && cur_has_sav) begin
            psr_cur <= psr_saved[cur_sav];
        end else if (branch_exchange) begin
            psr_cur[BIT_STATE] <= exch_operand[0];
        end else if (status_write && !status_saved_sel && mode != MODE_USR) begin
            psr_cur <= (psr_cur & ~PSR_WMASK) | (status_wdata & PSR_WMASK);
        end else if (status_write && !status_saved_sel) begin
            // user mode may only change the flags
            psr_cur[31:28] <= status_wdata[31:28];
        end else if (flags_write) begin
            psr_cur[31:28] <= flags_in;
        end
    end

    // saved status words: filled on exception entry other than reset, writable in modes that own one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_PSR-1; i++) begin
                psr_saved[i] <= 32'h00000000;
            end
        end else if (exc_take && exc_kind != EXC_RESET) begin
            psr_saved[exc_sav] <= psr_cur;
        end else if (status_write && status_saved_sel && cur_has_sav) begin
            psr_saved[cur_sav] <= (psr_saved[cur_sav] & ~PSR_WMASK)
                | (status_wdata & PSR_WMASK);
        end
    end

    // registered read ports with the banked view of the current mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_a_data <= 32'h00000000;
            rd_b_data <= 32'h00000000;
        end else begin
            rd_a_data <= (rd_a_idx == REG_PC) ? pc_aligned : gpr[slot_of(mode, rd_a_idx)];
            rd_b_data <= (rd_b_idx == REG_PC) ? pc_aligned : gpr[slot_of(mode, rd_b_idx)];
        end
    end

    // status, pc and state outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            current_status_word <= 32'h00000000;
            saved_status_word <= 32'h00000000;
            program_counter_reg <= 32'h00000000;
            state_indicator_signal <= 1'b0;
            privileged <= 1'b0;
        end else begin
            current_status_word <= psr_cur;
            saved_status_word <= cur_has_sav ? psr_saved[cur_sav] : 32'h00000000;
            program_counter_reg <= pc_aligned;
            state_indicator_signal <= psr_cur[BIT_STATE];
            privileged <= (mode != MODE_USR);
        end
    end

    // instruction fetch: compact state picks a halfword by pc bit 1, per endianness
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_half <= 16'h0000;
        end else if (pc_aligned[1] ^ big_endian) begin
            fetch_half <= fetch_word[31:16];
        end else begin
            fetch_half <= fetch_word[15:0];
        end
    end

    // data lane steering: byte n of a word sits on lanes chosen by endianness
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lane_data <= 32'h00000000;
            lane_strobe <= 4'h0;
            align_fault <= 1'b0;
        end else if (!lane_req.en) begin
            lane_strobe <= 4'h0;
            align_fault <= 1'b0;
        end else begin
            case (lane_req.size)
                SZ_BYTE: begin
                    align_fault <= 1'b0;
                    lane_data <= {4{lane_req.data[7:0]}};
                    // big: byte 0 on 31:24; little: byte 0 on 7:0
                    lane_strobe <= big_endian ? (4'h8 >> lane_req.addr)
                        : (4'h1 << lane_req.addr);
                end
                SZ_HALF: begin
                    align_fault <= lane_req.addr[0];
                    lane_data <= {2{lane_req.data[15:0]}};
                    lane_strobe <= lane_req.addr[0] ? 4'h0
                        : ((lane_req.addr[1] ^ big_endian) ? 4'hC : 4'h3);
                end
                SZ_WORD: begin
                    align_fault <= (lane_req.addr != 2'b00);
                    lane_data <= lane_req.data;
                    lane_strobe <= (lane_req.addr != 2'b00) ? 4'h0 : 4'hF;
                end
                default: begin
                    align_fault <= 1'b1;
                    lane_strobe <= 4'h0;
                end
            endcase
        end
    end

    // interrupt gating by the disable bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_take <= 1'b0;
            fiq_take <= 1'b0;
        end else begin
            irq_take <= irq_req && !psr_cur[BIT_IRQ_DIS];
            fiq_take <= fiq_req && !psr_cur[BIT_FIQ_DIS];
        end
    end
endmodule
`default_nettype wire

/* banked_core_register_file_properties.sv */
// checker for the banked register file: state bit, pc alignment, masking, lanes
// assumes it is bound to banked_core_register_file and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module banked_core_register_file_properties
    import regfile_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic branch_exchange,
    input wire logic [31:0] exch_operand,
    input wire logic exc_take,
    input wire regfile_pkg::exc_t exc_kind,
    input wire logic exc_return,
    input wire logic [31:0] fetch_word,
    input wire logic big_endian,
    input wire regfile_pkg::lane_req_t lane_req,
    input wire logic [31:0] current_status_word,
    input wire logic [31:0] program_counter_reg,
    input wire logic [15:0] fetch_half,
    input wire logic [3:0] lane_strobe,
    input wire logic align_fault,
    input wire logic state_indicator_signal,
    input wire logic privileged,
    input wire logic irq_take,
    input wire logic fiq_take
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // expected vector of each exception kind, indexed by its code
    localparam logic [31:0] EXC_VECS [7] = '{VEC_RESET, VEC_UND, VEC_SWI, VEC_PABT, VEC_DABT,
        VEC_IRQ, VEC_FIQ};
    // a state switch only counts when no higher-priority request shares its edge
    sequence seq_exch_plain;
        branch_exchange && !exc_take && !exc_return;
    endsequence
    sequence seq_misaligned;
        lane_req.en && ((lane_req.size == SZ_HALF && lane_req.addr[0]) ||
            (lane_req.size == SZ_WORD && lane_req.addr != 2'h0));
    endsequence
    chk_pc_wide_zero: assert property (
        !state_indicator_signal |-> program_counter_reg[1:0] == 2'h0)
        else $error("pc low bits set in wide state");
    chk_pc_half_zero: assert property (
        program_counter_reg[0] == 1'b0) else $error("pc bit 0 set");
    chk_state_bit_pin: assert property (
        state_indicator_signal == current_status_word[BIT_STATE])
        else $error("state pin differs from status bit");
    // outputs hold reset zeros one edge past release
    chk_priv_mode: assert property (
        !$past(rst) |-> privileged == (current_status_word[4:0] != MODE_USR))
        else $error("privilege flag wrong for mode");
    chk_exc_entry: assert property (
        exc_take |-> ##2 (!state_indicator_signal &&
            program_counter_reg == EXC_VECS[$past(exc_kind, 2)]))
        else $error("wrong exception entry");
    chk_exch_state: assert property (
        seq_exch_plain |-> ##2 state_indicator_signal == $past(exch_operand[0], 2))
        else $error("branch exchange state wrong");
    chk_irq_masked: assert property (
        current_status_word[BIT_IRQ_DIS] |-> !irq_take)
        else $error("masked normal interrupt taken");
    chk_fiq_masked: assert property (
        current_status_word[BIT_FIQ_DIS] |-> !fiq_take)
        else $error("masked fast interrupt taken");
    chk_byte_lane: assert property (
        lane_req.en && lane_req.size == SZ_BYTE |=> lane_strobe == ($past(big_endian) ?
            4'h8 >> $past(lane_req.addr) : 4'h1 << $past(lane_req.addr)))
        else $error("byte lane strobe wrong");
    chk_misaligned: assert property (
        seq_misaligned |=> align_fault && lane_strobe == 4'h0)
        else $error("misaligned access not refused");
    chk_fetch_half: assert property (
        state_indicator_signal |->
            fetch_half == ((program_counter_reg[1] ^ $past(big_endian)) ?
            $past(fetch_word[31:16]) : $past(fetch_word[15:0])))
        else $error("wrong fetch halfword");
endmodule
bind banked_core_register_file banked_core_register_file_properties
    banked_core_register_file_properties_inst (
    .core_clk(core_clk), .rst(rst), .branch_exchange(branch_exchange),
    .exch_operand(exch_operand), .exc_take(exc_take), .exc_kind(exc_kind),
    .exc_return(exc_return), .fetch_word(fetch_word), .big_endian(big_endian),
    .lane_req(lane_req), .current_status_word(current_status_word),
    .program_counter_reg(program_counter_reg), .fetch_half(fetch_half),
    .lane_strobe(lane_strobe), .align_fault(align_fault),
    .state_indicator_signal(state_indicator_signal), .privileged(privileged),
    .irq_take(irq_take), .fiq_take(fiq_take));
`default_nettype wire

/* regfile_pkg.sv */
// package for the banked core register file: modes, status word layout, vectors
// assumes a single core clock domain; all users import the whole package
`default_nettype none
package regfile_pkg;
    // mode field encodings
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [4:0] MODE_SYS = 5'h1F;
    // status word field positions
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam int BIT_IRQ_DIS = 7;
    localparam int BIT_FIQ_DIS = 6;
    localparam int BIT_STATE = 5;
    localparam int MODE_LSB = 0;
    // fields writable by software: flags and the 8 control bits
    localparam logic [31:0] PSR_WMASK = 32'hF00000FF;
    // status word after reset: supervisor, both interrupts masked, wide state
    localparam logic [31:0] PSR_RESET = 32'h000000D3;
    // exception vectors
    localparam logic [31:0] VEC_RESET = 32'h00000000;
    localparam logic [31:0] VEC_UND = 32'h00000004;
    localparam logic [31:0] VEC_SWI = 32'h00000008;
    localparam logic [31:0] VEC_PABT = 32'h0000000C;
    localparam logic [31:0] VEC_DABT = 32'h00000010;
    localparam logic [31:0] VEC_IRQ = 32'h00000018;
    localparam logic [31:0] VEC_FIQ = 32'h0000001C;
    // register numbers
    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [3:0] REG_LR = 4'hE;
    localparam logic [3:0] REG_PC = 4'hF;
    // physical storage: 31 general registers plus 6 status registers
    localparam int NUM_GPR = 31;
    localparam int NUM_PSR = 6;
    // physical slot indices
    localparam logic [4:0] SLOT_FIQ8 = 5'h0F;
    localparam logic [4:0] SLOT_USR_SP = 5'h0D;
    localparam logic [4:0] SLOT_SVC_SP = 5'h16;
    localparam logic [4:0] SLOT_ABT_SP = 5'h18;
    localparam logic [4:0] SLOT_IRQ_SP = 5'h1A;
    localparam logic [4:0] SLOT_UND_SP = 5'h1C;
    localparam logic [4:0] SLOT_PC = 5'h1E;
    // instruction state
    typedef enum logic [0:0] {
        ST_WIDE = 1'b0,
        ST_COMPACT = 1'b1
    } istate_t;
    // exception kinds
    typedef enum logic [2:0] {
        EXC_RESET = 3'b000,
        EXC_UND = 3'b001,
        EXC_SWI = 3'b010,
        EXC_PABT = 3'b011,
        EXC_DABT = 3'b100,
        EXC_IRQ = 3'b101,
        EXC_FIQ = 3'b110
    } exc_t;
    // access size of a data transfer
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } dsize_t;
    // one register write request
    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic [31:0] data;
    } reg_wr_t;
    // one data lane request
    typedef struct packed {
        logic en;
        dsize_t size;
        logic [1:0] addr;
        logic [31:0] data;
    } lane_req_t;
endpackage
`default_nettype wire

/* test_banked_core_register_file.sv */
// self-checking bench for the banked register file
// assumes regfile_pkg and the design are compiled first; one 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
module test_banked_core_register_file;
    import regfile_pkg::*;
    localparam logic [4:0] MODES [6] = '{MODE_SVC, MODE_IRQ, MODE_ABT, MODE_UND, MODE_FIQ,
        MODE_SYS};
    logic core_clk = 1'b0, rst = 1'b1, big_endian = 1'b0, irq_req = 1'b0, fiq_req = 1'b0;
    logic advance = 1'b0, branch_exchange = 1'b0, branch_with_link = 1'b0;
    logic status_write = 1'b0, status_saved_sel = 1'b0, flags_write = 1'b0;
    logic exc_take = 1'b0, exc_return = 1'b0;
    logic [3:0] rd_idx = 4'h0, flags_in = 4'h0, lane_strobe;
    logic [31:0] exch_operand = '0, branch_target = '0, status_wdata = '0;
    logic [31:0] return_addr = '0, fetch_word = '0;
    exc_t exc_kind = EXC_RESET;
    reg_wr_t wr_req = '0;
    lane_req_t lane_req = '0;
    logic [31:0] rd_a_data, rd_b_data, current_status_word, saved_status_word;
    logic [31:0] program_counter_reg, lane_data;
    logic [15:0] fetch_half;
    logic align_fault, state_indicator_signal, privileged, irq_take, fiq_take;
    int bad_count = 0, total_checks = 0, cycles = 0;
    // every other port meets the bench signal of the same name
    banked_core_register_file banked_core_register_file_inst (.rd_a_idx(rd_idx),
        .rd_b_idx(rd_idx), .*);
    // free-running core clock, 4 ns period
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // a clean run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // four-state compare so an unknown never matches
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // let two-edge state-to-output latency pass with margin, then sample settled
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // drop every one-cycle request one edge after it was raised
    task automatic end_op();
        @(posedge core_clk);
        wr_req.en <= 1'b0; advance <= 1'b0; branch_exchange <= 1'b0;
        branch_with_link <= 1'b0; status_write <= 1'b0; flags_write <= 1'b0;
        exc_take <= 1'b0; exc_return <= 1'b0;
        settle();
    endtask
    task automatic wreg(input logic [3:0] i, input logic [31:0] d);
        @(posedge core_clk); wr_req <= '{1'b1, i, d}; end_op();
    endtask
    task automatic wstat(input logic sel, input logic [31:0] v);
        @(posedge core_clk); status_write <= 1'b1; status_saved_sel <= sel;
        status_wdata <= v; end_op();
    endtask
    task automatic exc(input exc_t k);
        @(posedge core_clk); exc_take <= 1'b1; exc_kind <= k; end_op();
    endtask
    task automatic xchg(input logic [31:0] v);
        @(posedge core_clk); branch_exchange <= 1'b1; exch_operand <= v; end_op();
    endtask
    // both read ports look at the same index and must agree
    task automatic rreg(input logic [3:0] i, input logic [31:0] exp);
        @(posedge core_clk); rd_idx <= i; settle();
        chk32(rd_a_data, exp);
        chk32(rd_b_data, exp);
    endtask
    task automatic t_reset();
        settle();
        chk32(current_status_word, PSR_RESET);
        chk32(program_counter_reg, VEC_RESET);
        chk32({31'h0, privileged}, 32'h1);
        $display("test reset done");
    endtask
    // each privileged mode writes sp, r8 and r0, then reads them back
    task automatic t_bank();
        for (int i = 0; i < 6; i++) begin
            wstat(1'b0, {24'h0, 3'b110, MODES[i]});
            wreg(REG_SP, 32'h100 + i);
            wreg(4'h8, 32'h200 + i);
            wreg(4'h0, 32'h300 + i);
        end
        for (int i = 0; i < 6; i++) begin
            wstat(1'b0, {24'h0, 3'b110, MODES[i]});
            chk32({27'h0, current_status_word[4:0]}, {27'h0, MODES[i]});
            rreg(REG_SP, 32'h100 + i);
            rreg(4'h8, (MODES[i] == MODE_FIQ) ? 32'h204 : 32'h205);
            rreg(4'h0, 32'h305);
        end
        wstat(1'b0, 32'h000000D0);
        rreg(REG_SP, 32'h105);
        chk32({31'h0, privileged}, 32'h0);
        wstat(1'b0, 32'hA00000D3);
        chk32(current_status_word, 32'hA00000D0);
        wreg(REG_PC, 32'h00000040);
        exc(EXC_SWI);
        chk32(current_status_word, 32'hA00000D3);
        chk32(saved_status_word, 32'hA00000D0);
        chk32(program_counter_reg, VEC_SWI);
        rreg(REG_LR, 32'h00000040);
        $display("test banking done");
    endtask
    task automatic t_state();
        xchg(32'h00001001);
        chk32({31'h0, state_indicator_signal}, 32'h1);
        chk32(program_counter_reg, 32'h00001000);
        chk32(current_status_word, 32'hA00000F3);
        rreg(REG_SP, 32'h100);
        @(posedge core_clk); advance <= 1'b1; fetch_word <= 32'hAAAA5555; end_op();
        chk32(program_counter_reg, 32'h00001002);
        chk32({16'h0, fetch_half}, 32'hAAAA);
        @(posedge core_clk); big_endian <= 1'b1; settle();
        chk32({16'h0, fetch_half}, 32'h5555);
        @(posedge core_clk); branch_with_link <= 1'b1; branch_target <= 32'h2000; end_op();
        chk32(program_counter_reg, 32'h00002000);
        rreg(REG_LR, 32'h00001004);
        exc(EXC_IRQ);
        chk32(current_status_word, 32'hA00000D2);
        chk32(saved_status_word, 32'hA00000F3);
        rreg(REG_LR, 32'h00002000);
        @(posedge core_clk); exc_return <= 1'b1; return_addr <= 32'h2000; end_op();
        chk32(current_status_word, 32'hA00000F3);
        chk32(program_counter_reg, 32'h00002000);
        xchg(32'h00003000);
        chk32({31'h0, state_indicator_signal}, 32'h0);
        $display("test state done");
    endtask
    // every size, offset and byte order; misaligned ones must be refused
    task automatic t_lanes();
        logic [3:0] exp;
        logic bad;
        for (int be = 0; be < 2; be++) begin
            for (int sz = 0; sz < 3; sz++) begin
                for (int a = 0; a < 4; a++) begin
                    bad = (sz == 1 && a[0]) || (sz == 2 && a != 0);
                    if (bad) exp = 4'h0;
                    else if (sz == 0) exp = be[0] ? 4'h8 >> a : 4'h1 << a;
                    else if (sz == 1) exp = (a[1] ^ be[0]) ? 4'hC : 4'h3;
                    else exp = 4'hF;
                    @(posedge core_clk);
                    big_endian <= be[0];
                    lane_req <= '{1'b1, dsize_t'(sz), a[1:0], 32'h12345678};
                    settle();
                    chk32({28'h0, lane_strobe}, {28'h0, exp});
                    chk32({31'h0, align_fault}, {31'h0, bad});
                    chk32(lane_data, (sz == 0) ? 32'h78787878 : (sz == 1) ? 32'h56785678
                        : 32'h12345678);
                end
            end
        end
        @(posedge core_clk); lane_req.en <= 1'b0;
        $display("test lanes done");
    endtask
    task automatic t_irq();
        @(posedge core_clk); irq_req <= 1'b1; fiq_req <= 1'b1;
        wstat(1'b0, 32'h00000013);
        chk32({30'h0, irq_take, fiq_take}, 32'h3);
        wstat(1'b0, 32'h00000093);
        chk32({30'h0, irq_take, fiq_take}, 32'h1);
        wstat(1'b0, 32'h00000053);
        chk32({30'h0, irq_take, fiq_take}, 32'h2);
        wstat(1'b1, 32'h0F0000D1);
        chk32(saved_status_word, 32'h000000D1);
        @(posedge core_clk); flags_write <= 1'b1; flags_in <= 4'h5; end_op();
        chk32(current_status_word, 32'h50000053);
        @(posedge core_clk); irq_req <= 1'b0; fiq_req <= 1'b0;
        $display("test interrupts done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_bank();
        t_state();
        t_lanes();
        t_irq();
        stop_test();
    end
endmodule
`default_nettype wire
